// *** rtl/pdo_cmd_pkg.sv ***
// constants for the process-data motion and sequence command handler
// assumes a single 125 MHz clock domain and an APB register port
package pdo_cmd_pkg;

   // ======================================================================
   // register offsets (byte addresses)
   localparam logic [7:0]  rpdo_low_offset    = 8'h00;
   localparam logic [7:0]  rpdo_high_offset   = 8'h04;
   localparam logic [7:0]  sysmask_offset     = 8'h08;
   localparam logic [7:0]  status_offset      = 8'h0C;
   localparam logic [7:0]  tpdo_offset        = 8'h10;

   // ======================================================================
   // receive object field positions
   localparam int          remote_lsb         = 0;
   localparam int          start_bit_pos      = 8;
   localparam int          mcp_bit_pos        = 9;
   localparam int          mcn_bit_pos        = 10;
   localparam int          abort_bit_pos      = 12;
   localparam int          command_lsb        = 16;
   localparam int          trigger_bit_pos    = 30;

   // ======================================================================
   // reset values
   localparam logic [31:0] rpdo_low_reset     = 32'h0000_0000;
   localparam logic [31:0] rpdo_high_reset    = 32'h0000_0000;
   localparam logic [7:0]  sysmask_reset      = 8'h00;

   // ======================================================================
   // message command codes
   localparam logic [13:0] code_move_pos      = 14'h1C12;
   localparam logic [13:0] code_run_seq       = 14'h1C05;
   localparam logic [13:0] code_stop_first    = 14'h1C00;
   localparam logic [13:0] code_stop_last     = 14'h1C04;

   // ======================================================================
   // sequence numbers
   localparam logic [6:0]  seq_max            = 7'h63;

   // ======================================================================
   // motion state
   typedef enum logic [3:0] {
      mot_idle = 4'b0001,
      mot_pos  = 4'b0010,
      mot_neg  = 4'b0100,
      mot_seq  = 4'b1000
   } motion_e;

endpackage : pdo_cmd_pkg

// *** rtl/rise_detect.sv ***
// rising edge detector for one same-clock level
// assumes the input is already in the mclk domain
`timescale 1ns/1ps
module rise_detect
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic level,
   output logic      rise
);
   logic level_q;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         level_q <= 1'b0;
      else
         level_q <= level;
   end

   assign rise = level & ~level_q;
endmodule : rise_detect

// *** rtl/prog_select.sv ***
// program number built from remote input bits, system bits forced to zero
// assumes mask and inputs are stable in the mclk domain
`timescale 1ns/1ps
module prog_select
(
   input  wire logic [7:0] remote_input_bits,
   input  wire logic [7:0] system_mask,
   output logic [6:0]      program_number
);
   genvar i;
   generate
      for (i = 0; i < 7; i++)
      begin : g_bit
         // assigned system inputs contribute zero
         assign program_number[i] = remote_input_bits[i] & ~system_mask[i];
      end
   endgenerate
endmodule : prog_select

// *** rtl/pdo_motion_sequence_command_handler.sv ***
// What this block does
// - code 1C12h in the command area asks for continuous positive motion
// - trigger rising with 1C12h loaded starts positive rotation
// - stop codes loaded then trigger raised make the device stop
// - start bit going high runs program encoded on remote inputs
// - remote bits assigned to system functions excluded from program select
// - system-assigned remote bits count as zero in program number
// - run code 1C05h with program number in data runs that program
// - trigger rising with run code starts program named in data
// - start acts on rising edge, program 0 to 99 from inputs one to seven
//
// top of the handler: receive object written over APB, transmit read back
// assumes an APB master on mclk; motion outputs feed a motor sequencer
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pdo_motion_sequence_command_handler
   import pdo_cmd_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             move_positive_q,
   output logic             move_negative_q,
   output logic             seq_start_pulse_q,
   output logic [6:0]       seq_number_q,
   output logic             stop_pulse_q,
   output logic             trigger_acknowledge_bit
);
   import pdo_cmd_pkg::*;

   // ======================================================================
   // registers
   logic [31:0] rpdo_low_q;
   logic [31:0] rpdo_high_q;
   logic [7:0]  sysmask_q;
   logic        cmd_error_q;
   logic        start_ack_q;
   motion_e     motion_q;
   motion_e     motion_d;

   logic [7:0]  remote_input_bits;
   logic        start_level;
   logic        move_positive_continuous_bit;
   logic        move_negative_continuous_bit;
   logic        abort_level;
   logic [15:0] command_word;
   logic        command_trigger_bit;
   logic [15:0] data_word;
   logic [6:0]  remote_program;
   logic        start_rise;
   logic        command_trigger_bit_rise;
   logic        is_move_pos;
   logic        is_run;
   logic        is_stop;
   logic        do_start;
   logic        do_stop;
   logic        access;

   // command decode helpers and next values
   logic [13:0] cmd_code;
   logic        cmd_plain;
   logic        in_stop_range;
   logic [31:0] rdata_d;
   logic        rerr_d;
   logic [6:0]  seq_number_d;

   assign remote_input_bits            = rpdo_low_q[remote_lsb +: 8];
   assign start_level                  = rpdo_low_q[start_bit_pos];
   assign move_positive_continuous_bit = rpdo_low_q[mcp_bit_pos];
   assign move_negative_continuous_bit = rpdo_low_q[mcn_bit_pos];
   assign abort_level                  = rpdo_low_q[abort_bit_pos];
   assign command_word                 = rpdo_low_q[command_lsb +: 16];
   assign command_trigger_bit          = rpdo_low_q[trigger_bit_pos];
   assign data_word                    = rpdo_high_q[15:0];
   assign access                       = psel & penable;

   // ======================================================================
   // edge detection and program selection
   rise_detect u_start_edge
   (
      .mclk  (mclk),
      .rst   (rst),
      .level (start_level),
      .rise  (start_rise)
   );

   rise_detect u_command_trigger_bit_edge
   (
      .mclk  (mclk),
      .rst   (rst),
      .level (command_trigger_bit),
      .rise  (command_trigger_bit_rise)
   );

   prog_select u_prog
   (
      .remote_input_bits (remote_input_bits),
      .system_mask       (sysmask_q),
      .program_number    (remote_program)
   );

   // ======================================================================
   // command decode
   // bit 14 of the command half is the trigger itself, kept out of the code compare
   // a code outside the decoded set only raises the error flag
   assign cmd_code      = command_word[13:0];
   assign cmd_plain     = ~command_word[15];
   assign in_stop_range = cmd_code >= code_stop_first && cmd_code <= code_stop_last;
   assign is_move_pos   = command_trigger_bit_rise && cmd_plain
                          && cmd_code == code_move_pos;
   assign is_run        = command_trigger_bit_rise && cmd_plain
                          && cmd_code == code_run_seq
                          && data_word <= {9'h000, seq_max};
   assign is_stop       = command_trigger_bit_rise && cmd_plain
                          && in_stop_range;
   assign do_start    = (start_rise && remote_program <= seq_max) || is_run;
   assign do_stop     = is_stop || abort_level;

   // ======================================================================
   // APB slave
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rpdo_low_q  <= rpdo_low_reset;
         rpdo_high_q <= rpdo_high_reset;
         sysmask_q   <= sysmask_reset;
      end
      else if (access && pwrite)
      begin
         unique case (paddr)
            rpdo_low_offset:  rpdo_low_q  <= pwdata;
            rpdo_high_offset: rpdo_high_q <= pwdata;
            sysmask_offset:   sysmask_q   <= pwdata[7:0];
            default:          ;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable)
         begin
            prdata  <= rdata_d;
            pslverr <= rerr_d;
         end
      end
   end

   // read word and unmapped-address flag for the current setup address
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      rerr_d  = 1'b0;
      unique case (paddr)
         rpdo_low_offset:  rdata_d = rpdo_low_q;
         rpdo_high_offset: rdata_d = rpdo_high_q;
         sysmask_offset:   rdata_d = {24'h000000, sysmask_q};
         status_offset:    rdata_d = {24'h000000, cmd_error_q, start_ack_q,
                                      motion_q, 2'b00};
         tpdo_offset:      rdata_d = {1'b0, trigger_acknowledge_bit,
                                      command_word[13:0], 16'h0000};
         default:          rerr_d  = 1'b1;
      endcase
   end

   // ======================================================================
   // motion state
   // next motion state; a stop wins over any start in the same cycle
   always_comb
   begin
      motion_d = motion_q;
      if (do_stop)
         motion_d = mot_idle;
      else if (is_move_pos)
         motion_d = mot_pos;
      else if (do_start)
         motion_d = mot_seq;
      else
      begin
         unique case (motion_q)
            mot_idle:
            begin
               if (move_negative_continuous_bit)
                  motion_d = mot_neg;
               else if (move_positive_continuous_bit)
                  motion_d = mot_pos;
            end
            mot_pos:  motion_d = mot_pos;
            mot_neg:  motion_d = mot_neg;
            mot_seq:  motion_d = mot_seq;
            default:  motion_d = mot_idle;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         motion_q <= mot_idle;
      else
         motion_q <= motion_d;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         move_positive_q <= 1'b0;
         move_negative_q <= 1'b0;
      end
      else
      begin
         move_positive_q <= motion_q == mot_pos;
         move_negative_q <= motion_q == mot_neg;
      end
   end

   // ======================================================================
   // sequence start
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         seq_start_pulse_q <= 1'b0;
         seq_number_q      <= 7'h00;
      end
      else
      begin
         seq_start_pulse_q <= do_start && !do_stop;
         seq_number_q      <= seq_number_d;
      end
   end

   // run command takes the data area, the start bit takes the remote inputs
   always_comb
   begin
      seq_number_d = seq_number_q;
      if (is_run)
         seq_number_d = data_word[6:0];
      else if (start_rise)
         seq_number_d = remote_program;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         stop_pulse_q <= 1'b0;
      else
         stop_pulse_q <= is_stop;
   end

   // ======================================================================
   // handshake acknowledge
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         trigger_acknowledge_bit <= 1'b0;
      else
         trigger_acknowledge_bit <= command_trigger_bit;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         start_ack_q <= 1'b0;
         cmd_error_q <= 1'b0;
      end
      else
      begin
         start_ack_q <= start_level;
         if (command_trigger_bit_rise)
            cmd_error_q <= !(is_move_pos || is_run || is_stop);
      end
   end

endmodule : pdo_motion_sequence_command_handler

// *** verification/pdo_cmd_props.sv ***
// assertion checker for the command handler top
// assumes it is bound onto the handler top module
`timescale 1ns/1ps
module pdo_cmd_props
   import pdo_cmd_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        move_positive_q,
   input wire logic        move_negative_q,
   input wire logic        seq_start_pulse_q,
   input wire logic [6:0]  seq_number_q,
   input wire logic        stop_pulse_q,
   input wire logic        trigger_acknowledge_bit
);
   // ======================================================================
   // shadows of the written words
   logic [31:0] w0_q;
   logic [31:0] d_q;
   logic [7:0]  m_q;
   wire         wr_ok = psel && penable && pready && pwrite;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         w0_q <= 32'h0;
         d_q  <= 32'h0;
         m_q  <= 8'h00;
      end
      else if (wr_ok)
      begin
         if (paddr == rpdo_low_offset) w0_q <= pwdata;
         if (paddr == rpdo_high_offset) d_q <= pwdata;
         if (paddr == sysmask_offset) m_q <= pwdata[7:0];
      end
   end
   // ======================================================================
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_pos_cause: assert property ($rose(move_positive_q) |->
      w0_q[mcp_bit_pos] || w0_q[29:16] == code_move_pos) else $error("positive move uncaused");
   chk_stop_halts: assert property (stop_pulse_q |-> ##[0:2]
      !move_positive_q && !move_negative_q) else $error("stop left motion");
   chk_stop_single: assert property (stop_pulse_q |=> !stop_pulse_q)
      else $error("stop pulse too long");
   chk_start_single: assert property (seq_start_pulse_q |=> !seq_start_pulse_q)
      else $error("start pulse too long");
   chk_seq_range: assert property (seq_start_pulse_q |-> seq_number_q <= seq_max)
      else $error("program number over range");
   chk_seq_cause: assert property (seq_start_pulse_q |->
      w0_q[start_bit_pos] || w0_q[trigger_bit_pos]) else $error("start uncaused");
   chk_seq_masked: assert property (seq_start_pulse_q && !w0_q[trigger_bit_pos] |->
      seq_number_q == (w0_q[6:0] & ~m_q[6:0])) else $error("remote program wrong");
   chk_run_data: assert property (seq_start_pulse_q && w0_q[trigger_bit_pos] |->
      seq_number_q == d_q[6:0]) else $error("run program wrong");
   chk_ack_follow: assert property ($rose(w0_q[trigger_bit_pos]) |->
      ##[0:2] trigger_acknowledge_bit) else $error("no trigger acknowledge");
endmodule : pdo_cmd_props
bind pdo_motion_sequence_command_handler pdo_cmd_props i_pdo_cmd_props (.*);

// *** verification/pdo_master_model.sv ***
// network master model driving apb transfers into the handler
// assumes one mclk domain; one transfer at a time
`timescale 1ns/1ps
module pdo_master_model
(
   input  wire logic        mclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // ======================================================================
   // one apb transfer, waits for pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask : xfer
endmodule : pdo_master_model

// *** verification/pdo_motion_sequence_command_handler_tb.sv ***
// self-checking bench for the command handler
// assumes the master model and checker files are compiled first
`timescale 1ns/1ps
module pdo_motion_sequence_command_handler_tb;
   import pdo_cmd_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, rd_e;
   logic move_positive_q, move_negative_q, seq_start_pulse_q, stop_pulse_q;
   logic trigger_acknowledge_bit;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [6:0] seq_number_q, seq_seen;
   int bad_count = 0;
   int compares = 0;
   int seq_cnt = 0;
   int stop_cnt = 0;
   always #4 mclk = ~mclk;
   pdo_motion_sequence_command_handler i_pdo_motion_sequence_command_handler (.*);
   pdo_master_model i_pdo_master_model (.*);
   always @(posedge mclk)
   begin
      if (seq_start_pulse_q === 1'b1) seq_cnt++;
      if (seq_start_pulse_q === 1'b1) seq_seen = seq_number_q;
      if (stop_pulse_q === 1'b1) stop_cnt++;
   end
   // ======================================================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_pdo_master_model.xfer(1'b1, a, d, rd_q, rd_e);
      repeat (4) @(posedge mclk);
   endtask : wr
   task automatic mcmd(input logic [13:0] c, input logic [31:0] d);
      wr(rpdo_high_offset, d);
      wr(rpdo_low_offset, {2'b00, c, 16'h0000});
      wr(rpdo_low_offset, {2'b01, c, 16'h0000});
      chk({31'h0, trigger_acknowledge_bit}, 32'h1);
      i_pdo_master_model.xfer(1'b0, tpdo_offset, 32'h0, rd_q, rd_e);
      chk(rd_q, {2'b01, c, 16'h0000});
      wr(rpdo_low_offset, 32'h0);
   endtask : mcmd
   task automatic sel(input logic [7:0] r, input logic [7:0] m, input int f, input logic [6:0] v);
      int n;
      n = seq_cnt;
      wr(sysmask_offset, {24'h0, m});
      wr(rpdo_low_offset, {24'h0, r});
      wr(rpdo_low_offset, {23'h0, 1'b1, r});
      chk(seq_cnt, n + f);
      if (f == 1) chk({25'h0, seq_seen}, {25'h0, v});
      wr(rpdo_low_offset, {24'h0, r});
   endtask : sel
   task automatic wrap_up;
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // ======================================================================
   // tests
   initial
   begin
      #200000;
      bad_count++;
      wrap_up;
   end
   initial
   begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      i_pdo_master_model.xfer(1'b0, rpdo_low_offset, 32'h0, rd_q, rd_e);
      chk(rd_q, rpdo_low_reset);
      i_pdo_master_model.xfer(1'b0, sysmask_offset, 32'h0, rd_q, rd_e);
      chk(rd_q, {24'h0, sysmask_reset});
      i_pdo_master_model.xfer(1'b0, 8'h40, 32'h0, rd_q, rd_e);
      chk({rd_e, rd_q[30:0]}, 32'h8000_0000);
      mcmd(code_move_pos, 32'h0);
      chk({31'h0, move_positive_q}, 32'h1);
      i_pdo_master_model.xfer(1'b0, status_offset, 32'h0, rd_q, rd_e);
      chk(rd_q, {24'h00_0000, 2'b00, mot_pos, 2'b00});
      wr(rpdo_high_offset, 32'h3);
      wr(rpdo_low_offset, {2'b00, code_run_seq, 16'h0000});
      wr(rpdo_low_offset, {2'b01, code_run_seq, 16'h0000});
      chk(seq_cnt, 1);
      chk({25'h0, seq_seen}, 32'h3);
      wr(rpdo_low_offset, {2'b01, code_run_seq, 16'h0000});
      chk(seq_cnt, 1);
      wr(rpdo_low_offset, 32'h0);
      for (int c = code_stop_first; c <= code_stop_last; c++)
      begin
         mcmd(code_move_pos, 32'h0);
         mcmd(c[13:0], 32'h0);
         chk(stop_cnt, c - code_stop_first + 1);
         chk({31'h0, move_positive_q}, 32'h0);
      end
      wr(rpdo_low_offset, 32'h0000_0400);
      chk({31'h0, move_negative_q}, 32'h1);
      wr(rpdo_low_offset, 32'h0000_1000);
      chk({31'h0, move_negative_q}, 32'h0);
      wr(rpdo_low_offset, 32'h0000_0200);
      chk({31'h0, move_positive_q}, 32'h1);
      wr(rpdo_low_offset, 32'h0000_1000);
      chk({31'h0, move_positive_q}, 32'h0);
      wr(rpdo_low_offset, 32'h0);
      sel(8'h03, 8'h00, 1, 7'h03);
      sel(8'h03, 8'h01, 1, 7'h02);
      sel(8'h63, 8'h00, 1, 7'h63);
      sel(8'h64, 8'h00, 0, 7'h63);
      mcmd(14'h0FFF, 32'h0);
      i_pdo_master_model.xfer(1'b0, status_offset, 32'h0, rd_q, rd_e);
      chk(rd_q, {24'h00_0000, 1'b1, 1'b0, mot_seq, 2'b00});
      wrap_up;
   end
endmodule : pdo_motion_sequence_command_handler_tb
